/* File: crhh_map.svh */
// Constant map of the chain read and write-path handover block
`ifndef CRHH_MAP_SVH
`define CRHH_MAP_SVH
`define CRHH_OP_SINGLE 3'h5
`define CRHH_OP_BLOCK 3'h6
`define CRHH_CMD_TO_DOWN 8'h09
`define CRHH_CMD_TO_UP 8'h08
`define CRHH_HO_PAD 8'h00
`define CRHH_SEL_UP 1'h1
`define CRHH_IDX_CMD 5'h00
`define CRHH_IDX_ONE 5'h01
`define CRHH_IDX_TWO 5'h02
`define CRHH_STEP 5'h01
`define CRHH_BS_ONE 5'h01
`define CRHH_BS_TWO 5'h02
`define CRHH_START_SGL 5'h02
`define CRHH_START_BLK 5'h03
`define CRHH_INS_ONE 5'h02
`define CRHH_INS_TWO 5'h04
`define CRHH_ADDR_HI_ZERO 3'h0
`define CRHH_ALIVE_STEP 8'h01
`define CRHH_ZERO_BYTE 8'h00
`define CRHH_CRC_POLY 8'h07
`define CRHH_CRC_INIT 8'h00
`define CRHH_HOLD_DEPTH 4
`endif

/* File: crhh_pkg.sv */
// Types of the chain read and write-path handover block
package crhh_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_HDR = 4'h2,
        ST_INS = 4'h4,
        ST_PASS = 4'h8
    } crhh_state_t;
endpackage : crhh_pkg

/* File: crhh_core.sv */
// Chain read insertion and write-path handover engine
`timescale 1ns/1ps
`include "crhh_map.svh"

module crhh_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic rxLoValid,
    input wire logic [7:0] rxLoData,
    input wire logic rxLoSof,
    input wire logic rxLoEof,
    input wire logic rxLoMancErr,
    input wire logic rxUpValid,
    input wire logic [7:0] rxUpData,
    input wire logic rxUpSof,
    input wire logic rxUpEof,
    input wire logic rxUpMancErr,
    output logic txLoValid,
    output logic [7:0] txLoData,
    output logic txLoSof,
    output logic txLoEof,
    output logic txLoMancErr,
    output logic txUpValid,
    output logic [7:0] txUpData,
    output logic txUpSof,
    output logic txUpEof,
    output logic txUpMancErr,
    input wire logic [4:0] myDevAddr,
    input wire logic [4:0] chainBotAddr,
    input wire logic [4:0] chainTopAddr,
    input wire logic dualUartEn,
    input wire logic aliveEn,
    output logic [7:0] regRdAddr,
    input wire logic [15:0] regRdData,
    input wire logic regRdHit,
    input wire logic alertClr,
    output logic writePathSelect,
    output logic dualPathCmdAlert,
    output logic writeGrantLower,
    output logic writeGrantUpper
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    crhh_pkg::crhh_state_t state_reg;
    crhh_pkg::crhh_state_t stateNext;
    logic srcUp_reg;
    logic [4:0] idx_reg;
    logic [7:0] cmd_reg;
    logic [7:0] devAddr_reg;
    logic [7:0] crc_reg;
    logic [7:0] hold_reg [0:`CRHH_HOLD_DEPTH-1];
    logic sel_reg;
    logic alert_reg;
    logic startLo, src, inValid, inSof, inEof, inManc, take;
    logic [7:0] inData, outByte, dataByte, holdOut, txAny;
    logic [4:0] k, pos, insStart, nIns;
    logic sglCmd, blkCmd, bsTwo, devOk, addressed, insNow;
    logic hoSeen, toDown, rightPath, hoApply, hoInvalid;

    function automatic logic [7:0] crc8(input logic [7:0] c,
                                        input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++)
        begin
            r = r[7] ? ((r << 1) ^ `CRHH_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc8

    // ----------------------------------------
    // Source selection
    // ----------------------------------------
    // Lower port wins a same-cycle start; the other frame is dropped
    assign startLo = rxLoValid && rxLoSof;
    assign src = (state_reg == crhh_pkg::ST_IDLE) ? !startLo : srcUp_reg;
    assign inValid = src ? rxUpValid : rxLoValid;
    assign inData = src ? rxUpData : rxLoData;
    assign inSof = src ? rxUpSof : rxLoSof;
    assign inEof = src ? rxUpEof : rxLoEof;
    assign inManc = src ? rxUpMancErr : rxLoMancErr;
    assign take = inValid && (state_reg != crhh_pkg::ST_IDLE || inSof);
    assign k = (state_reg == crhh_pkg::ST_IDLE) ? `CRHH_IDX_CMD : idx_reg;

    // ----------------------------------------
    // Frame decode
    // ----------------------------------------
    assign sglCmd = cmd_reg[2:0] == `CRHH_OP_SINGLE;
    assign bsTwo = cmd_reg[7:3] == `CRHH_BS_TWO;
    assign blkCmd = cmd_reg[2:0] == `CRHH_OP_BLOCK &&
        (cmd_reg[7:3] == `CRHH_BS_ONE || bsTwo);
    assign devOk = devAddr_reg[7:5] == `CRHH_ADDR_HI_ZERO &&
        devAddr_reg[4:0] >= chainBotAddr &&
        devAddr_reg[4:0] <= chainTopAddr;
    assign addressed = sglCmd ?
        (cmd_reg[7:3] == myDevAddr && regRdHit) :
        (blkCmd && devOk && devAddr_reg[4:0] == myDevAddr);
    assign insStart = blkCmd ? `CRHH_START_BLK : `CRHH_START_SGL;
    assign nIns = (blkCmd && bsTwo) ? `CRHH_INS_TWO : `CRHH_INS_ONE;
    assign pos = k - insStart;
    assign holdOut = (blkCmd && bsTwo) ? hold_reg[3] : hold_reg[1];
    assign insNow = !inManc && (state_reg == crhh_pkg::ST_INS ||
        (state_reg == crhh_pkg::ST_HDR && k == insStart && addressed));
    assign dataByte = regRdHit ?
        (pos[0] ? regRdData[15:8] : regRdData[7:0]) :
        `CRHH_ZERO_BYTE;

    // ----------------------------------------
    // Handover decode
    // ----------------------------------------
    assign toDown = cmd_reg == `CRHH_CMD_TO_DOWN;
    assign hoSeen = take && state_reg == crhh_pkg::ST_HDR &&
        k == `CRHH_IDX_TWO && dualUartEn && !inManc &&
        devAddr_reg == `CRHH_HO_PAD &&
        (toDown || cmd_reg == `CRHH_CMD_TO_UP);
    assign rightPath = toDown ? srcUp_reg : !srcUp_reg;
    assign hoApply = hoSeen && rightPath &&
        (toDown == (sel_reg == `CRHH_SEL_UP));
    assign hoInvalid = hoSeen && !rightPath;

    // ----------------------------------------
    // Output byte and next state
    // ----------------------------------------
    always_comb
    begin
        outByte = inData;
        stateNext = state_reg;
        if (insNow)
        begin
            if (pos < nIns)
                outByte = dataByte;
            else if (pos == nIns + `CRHH_STEP)
                outByte = crc_reg;
            else if (pos == nIns + `CRHH_IDX_TWO && aliveEn)
                outByte = holdOut + `CRHH_ALIVE_STEP;
            else
                outByte = holdOut;
        end
        else if (hoApply)
        begin
            outByte = {inData[7:5], inData[4:0] + `CRHH_STEP};
        end
        if (take)
        begin
            unique case (state_reg)
                crhh_pkg::ST_IDLE: stateNext = crhh_pkg::ST_HDR;
                crhh_pkg::ST_HDR:
                begin
                    if (k == insStart)
                        stateNext = insNow ? crhh_pkg::ST_INS :
                            crhh_pkg::ST_PASS;
                end
                crhh_pkg::ST_INS: stateNext = crhh_pkg::ST_INS;
                crhh_pkg::ST_PASS: stateNext = crhh_pkg::ST_PASS;
            endcase
            if (inManc)
                stateNext = crhh_pkg::ST_PASS;
            if (inEof)
                stateNext = crhh_pkg::ST_IDLE;
        end
    end

    // ----------------------------------------
    // Frame tracking
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= crhh_pkg::ST_IDLE;
            srcUp_reg <= 1'b0;
            idx_reg <= `CRHH_IDX_CMD;
        end
        else
        begin
            state_reg <= stateNext;
            if (state_reg == crhh_pkg::ST_IDLE)
                srcUp_reg <= src;
            if (take)
                idx_reg <= inEof ? `CRHH_IDX_CMD : k + `CRHH_STEP;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cmd_reg <= `CRHH_ZERO_BYTE;
            devAddr_reg <= `CRHH_ZERO_BYTE;
            regRdAddr <= `CRHH_ZERO_BYTE;
        end
        else if (take)
        begin
            if (k == `CRHH_IDX_CMD)
                cmd_reg <= inData;
            if (k == `CRHH_IDX_ONE)
                devAddr_reg <= inData;
            if (state_reg == crhh_pkg::ST_HDR &&
                k == (blkCmd ? `CRHH_IDX_TWO : `CRHH_IDX_ONE))
                regRdAddr <= inData;
            else if (insNow && pos == `CRHH_IDX_ONE)
                regRdAddr <= regRdAddr + 8'(`CRHH_STEP);
        end
    end

    // Delay line that pushes trailing bytes back behind inserted data
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < `CRHH_HOLD_DEPTH; i++)
                hold_reg[i] <= `CRHH_ZERO_BYTE;
        end
        else if (take && insNow)
        begin
            hold_reg[0] <= inData;
            for (int i = 1; i < `CRHH_HOLD_DEPTH; i++)
                hold_reg[i] <= hold_reg[i-1];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            crc_reg <= `CRHH_CRC_INIT;
        else if (take)
            crc_reg <= crc8((k == `CRHH_IDX_CMD) ? `CRHH_CRC_INIT : crc_reg,
                outByte);
    end

    // ----------------------------------------
    // Transmit registers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            txLoValid <= 1'b0;
            txUpValid <= 1'b0;
            txLoData <= `CRHH_ZERO_BYTE;
            txUpData <= `CRHH_ZERO_BYTE;
            {txLoSof, txLoEof, txLoMancErr} <= 3'h0;
            {txUpSof, txUpEof, txUpMancErr} <= 3'h0;
        end
        else
        begin
            txLoValid <= take && src;
            txUpValid <= take && !src;
            txLoData <= outByte;
            txUpData <= outByte;
            {txLoSof, txLoEof, txLoMancErr} <= {inSof, inEof, inManc};
            {txUpSof, txUpEof, txUpMancErr} <= {inSof, inEof, inManc};
        end
    end

    // ----------------------------------------
    // Write ownership and alert
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            sel_reg <= `CRHH_SEL_UP;
        else if (hoApply)
            sel_reg <= toDown ? ~`CRHH_SEL_UP : `CRHH_SEL_UP;
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            alert_reg <= 1'b0;
        else if (hoInvalid)
            alert_reg <= 1'b1;
        else if (alertClr)
            alert_reg <= 1'b0;
    end

    assign writePathSelect = sel_reg;
    assign dualPathCmdAlert = alert_reg;
    assign writeGrantLower = !dualUartEn || sel_reg;
    assign writeGrantUpper = dualUartEn && !sel_reg;
    assign txAny = txLoValid ? txLoData : txUpData;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_ho_apply_down;
        hoApply && toDown;
    endsequence
    sequence s_ho_apply_up;
        hoApply && !toDown;
    endsequence
    sequence s_pec_slot;
        take && insNow && pos == nIns + `CRHH_STEP;
    endsequence

    property p_rst_sel;
        @(posedge clk) rst |=> writePathSelect && !dualPathCmdAlert;
    endproperty
    a_rst_sel: assert property (p_rst_sel)
        else $error("ownership not up after reset");

    property p_to_down;
        @(posedge clk) disable iff (rst) s_ho_apply_down |=>
            !writePathSelect && txLoValid &&
            txLoData[4:0] == $past(inData[4:0]) + `CRHH_STEP;
    endproperty
    a_to_down: assert property (p_to_down)
        else $error("down handover not taken");

    property p_to_up;
        @(posedge clk) disable iff (rst) s_ho_apply_up |=>
            writePathSelect && txUpValid &&
            txUpData[4:0] == $past(inData[4:0]) + `CRHH_STEP;
    endproperty
    a_to_up: assert property (p_to_up)
        else $error("up handover not taken");

    property p_alert;
        @(posedge clk) disable iff (rst) hoInvalid |=>
            dualPathCmdAlert && $stable(writePathSelect) &&
            txAny == $past(inData);
    endproperty
    a_alert: assert property (p_alert)
        else $error("invalid handover not flagged");

    property p_keep;
        @(posedge clk) disable iff (rst) hoSeen && !hoApply |=>
            $stable(writePathSelect) && txAny == $past(inData);
    endproperty
    a_keep: assert property (p_keep)
        else $error("owner handover modified frame");

    property p_single;
        @(posedge clk) disable iff (rst) !dualUartEn |=>
            $stable(writePathSelect) ##1 $stable(writePathSelect);
    endproperty
    a_single: assert property (p_single)
        else $error("ownership moved in single mode");

    property p_route;
        @(posedge clk) disable iff (rst) take && src |=>
            txLoValid && !txUpValid;
    endproperty
    a_route: assert property (p_route)
        else $error("down path frame on wrong port");

    property p_manc;
        @(posedge clk) disable iff (rst) take && inManc && !inEof |=>
            state_reg == crhh_pkg::ST_PASS && txAny == $past(inData);
    endproperty
    a_manc: assert property (p_manc)
        else $error("no pass-through after coding error");

    property p_pass;
        @(posedge clk) disable iff (rst)
            take && state_reg == crhh_pkg::ST_PASS |=>
            txAny == $past(inData);
    endproperty
    a_pass: assert property (p_pass)
        else $error("pass-through byte changed");

    property p_pec;
        @(posedge clk) disable iff (rst) s_pec_slot |=>
            txAny == $past(crc_reg);
    endproperty
    a_pec: assert property (p_pec)
        else $error("error code not recomputed");

    property p_zero;
        @(posedge clk) disable iff (rst)
            take && insNow && blkCmd && pos < nIns && !regRdHit |=>
            txAny == `CRHH_ZERO_BYTE;
    endproperty
    a_zero: assert property (p_zero)
        else $error("missing register not zero");
endmodule : crhh_core

/* File: crhh_reg_model.sv */
// Register file model seen by the core's read port
`timescale 1ns/1ps
module crhh_reg_model #(
    parameter int HIT_LIMIT = 128
) (
    input wire logic [7:0] regRdAddr,
    output logic [15:0] regRdData,
    output logic regRdHit
);
    // ------------------------------------------------------------
    // Storage, loaded by the bench
    // ------------------------------------------------------------
    logic [15:0] mem [0:255];

    // Unimplemented places answer junk, so a missing zero shows up
    always_comb
    begin
        regRdHit = int'(regRdAddr) < HIT_LIMIT;
        regRdData = regRdHit ? mem[regRdAddr] : ~mem[regRdAddr];
    end
endmodule : crhh_reg_model

/* File: test_chain_read_and_host_handover.sv */
// Self-checking bench of the chain read and handover core
`timescale 1ns/1ps
module test_chain_read_and_host_handover;
    localparam int HIT_LIMIT = 128;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic rxLoValid = 1'h0;
    logic [7:0] rxLoData = 8'h00;
    logic rxLoSof = 1'h0;
    logic rxLoEof = 1'h0;
    logic rxLoMancErr = 1'h0;
    logic rxUpValid = 1'h0;
    logic [7:0] rxUpData = 8'h00;
    logic rxUpSof = 1'h0;
    logic rxUpEof = 1'h0;
    logic rxUpMancErr = 1'h0;
    logic txLoValid, txLoSof, txLoEof, txLoMancErr;
    logic txUpValid, txUpSof, txUpEof, txUpMancErr;
    logic [7:0] txLoData;
    logic [7:0] txUpData;
    logic [4:0] myDevAddr = 5'h03;
    logic [4:0] chainBotAddr = 5'h01;
    logic [4:0] chainTopAddr = 5'h06;
    logic dualUartEn = 1'h1;
    logic aliveEn = 1'h1;
    logic alertClr = 1'h0;
    logic [7:0] regRdAddr;
    logic [15:0] regRdData;
    logic regRdHit;
    logic writePathSelect, dualPathCmdAlert;
    logic writeGrantLower, writeGrantUpper;
    logic [10:0] expLo[$];
    logic [10:0] expUp[$];
    logic [7:0] badDev [4] = '{8'h0a, 8'h23, 8'h00, 8'h02};
    logic [31:0] lfsr = 32'h0775;
    int n_mismatch = 0;
    int checks_done = 0;

    always #5 clk = ~clk;

    crhh_core dut_u (
        .clk(clk),
        .rst(rst),
        .rxLoValid(rxLoValid),
        .rxLoData(rxLoData),
        .rxLoSof(rxLoSof),
        .rxLoEof(rxLoEof),
        .rxLoMancErr(rxLoMancErr),
        .rxUpValid(rxUpValid),
        .rxUpData(rxUpData),
        .rxUpSof(rxUpSof),
        .rxUpEof(rxUpEof),
        .rxUpMancErr(rxUpMancErr),
        .txLoValid(txLoValid),
        .txLoData(txLoData),
        .txLoSof(txLoSof),
        .txLoEof(txLoEof),
        .txLoMancErr(txLoMancErr),
        .txUpValid(txUpValid),
        .txUpData(txUpData),
        .txUpSof(txUpSof),
        .txUpEof(txUpEof),
        .txUpMancErr(txUpMancErr),
        .myDevAddr(myDevAddr),
        .chainBotAddr(chainBotAddr),
        .chainTopAddr(chainTopAddr),
        .dualUartEn(dualUartEn),
        .aliveEn(aliveEn),
        .regRdAddr(regRdAddr),
        .regRdData(regRdData),
        .regRdHit(regRdHit),
        .alertClr(alertClr),
        .writePathSelect(writePathSelect),
        .dualPathCmdAlert(dualPathCmdAlert),
        .writeGrantLower(writeGrantLower),
        .writeGrantUpper(writeGrantUpper)
    );
    crhh_reg_model #(.HIT_LIMIT(HIT_LIMIT)) mdl_u (
        .regRdAddr(regRdAddr),
        .regRdData(regRdData),
        .regRdHit(regRdHit)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    function automatic logic [7:0] crc8(input logic [7:0] c,
        input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        repeat (8) r = r[7] ? {r[6:0], 1'h0} ^ 8'h07 : {r[6:0], 1'h0};
        return r;
    endfunction : crc8

    task automatic check(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    // Idle port gets inverted data so a port mix-up cannot match
    task automatic send(input logic onUp, input logic [7:0] f[$],
        input int errAt);
        logic [3:0] q;
        for (int i = 0; i < f.size(); i++)
        begin
            q = {1'h1, i == 0, i == f.size() - 1, i == errAt};
            @(posedge clk);
            {rxUpValid, rxUpSof, rxUpEof, rxUpMancErr} <= onUp ? q : 4'h0;
            {rxLoValid, rxLoSof, rxLoEof, rxLoMancErr} <= onUp ? 4'h0 : q;
            rxUpData <= onUp ? f[i] : ~f[i];
            rxLoData <= onUp ? ~f[i] : f[i];
        end
        @(posedge clk);
        {rxUpValid, rxUpSof, rxUpEof, rxUpMancErr} <= 4'h0;
        {rxLoValid, rxLoSof, rxLoEof, rxLoMancErr} <= 4'h0;
    endtask : send

    task automatic push_exp(input logic onUp, input logic [7:0] f[$],
        input int errAt);
        logic [10:0] e;
        for (int i = 0; i < f.size(); i++)
        begin
            e = {i == 0, i == f.size() - 1, i == errAt, f[i]};
            if (onUp)
                expLo.push_back(e);
            else
                expUp.push_back(e);
        end
    endtask : push_exp

    task automatic rd(input logic onUp, input logic [7:0] cmd,
        input logic [7:0] dev, input logic [7:0] ra, input logic ins,
        input int errAt);
        logic [7:0] fin[$];
        logic [7:0] fout[$];
        logic [7:0] crc;
        logic [7:0] alv;
        logic [7:0] a;
        int nw;
        int h;
        nw = (cmd == 8'h16) ? 2 : 1;
        alv = 8'(rnd());
        fin = '{cmd};
        if (cmd[2:0] == 3'h6) fin.push_back(dev);
        fin.push_back(ra);
        h = fin.size();
        fout = fin;
        fin.push_back(8'(rnd()));
        fin.push_back(8'(rnd()));
        if (aliveEn) fin.push_back(alv);
        repeat (nw)
        begin
            fin.push_back(8'hc2);
            fin.push_back(8'hd3);
        end
        for (int k = 0; k < nw; k++)
        begin
            a = ra + 8'(k);
            fout.push_back(int'(a) < HIT_LIMIT ? mdl_u.mem[a][7:0] : 8'h00);
            fout.push_back(int'(a) < HIT_LIMIT ? mdl_u.mem[a][15:8] : 8'h00);
        end
        fout.push_back(fin[h]);
        crc = 8'h00;
        foreach (fout[j]) crc = crc8(crc, fout[j]);
        fout.push_back(crc);
        if (aliveEn) fout.push_back(alv + 8'h01);
        // Past a coding error every character goes through untouched
        for (int j = errAt; j >= 0 && j < fin.size(); j++)
            fout[j] = fin[j];
        if (!ins) fout = fin;
        push_exp(onUp, fout, errAt);
        send(onUp, fin, errAt);
    endtask : rd

    task automatic chk_state(input logic sel, input logic alert);
        repeat (3) @(posedge clk);
        #1;
        check("writePathSelect", 16'(writePathSelect), 16'(sel));
        check("dualPathCmdAlert", 16'(dualPathCmdAlert), 16'(alert));
        check("grantLo", 16'(writeGrantLower), 16'(!dualUartEn || sel));
        check("grantUp", 16'(writeGrantUpper), 16'(dualUartEn && !sel));
    endtask : chk_state

    task automatic ho(input logic onUp, input logic [7:0] cmd,
        input logic [7:0] cnt, input logic [7:0] outCnt, input logic sel,
        input logic alert);
        logic [7:0] f[$];
        logic [7:0] g[$];
        f = '{cmd, 8'h00, cnt};
        g = '{cmd, 8'h00, outCnt};
        push_exp(onUp, g, -1);
        send(onUp, f, -1);
        chk_state(sel, alert);
        if (alert)
        begin
            @(posedge clk);
            alertClr <= 1'h1;
            @(posedge clk);
            alertClr <= 1'h0;
            chk_state(sel, 1'h0);
        end
    endtask : ho

    task automatic end_test(input string name);
        repeat (4) @(posedge clk);
        $display("test %s done", name);
    endtask : end_test

    // ------------------------------------------------------------
    // Output watcher
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (txLoValid === 1'h1)
        begin
            if (expLo.size() == 0)
                check("txLo extra", 16'h0001, 16'h0000);
            else
                check("txLo", 16'({txLoSof, txLoEof, txLoMancErr, txLoData}),
                    16'(expLo.pop_front()));
        end
        if (txUpValid === 1'h1)
        begin
            if (expUp.size() == 0)
                check("txUp extra", 16'h0001, 16'h0000);
            else
                check("txUp", 16'({txUpSof, txUpEof, txUpMancErr, txUpData}),
                    16'(expUp.pop_front()));
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        for (int i = 0; i < 256; i++) mdl_u.mem[i] = 16'(rnd());
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        chk_state(1'h1, 1'h0);
        end_test("reset");
        rd(1'h1, 8'h1d, 8'h00, {2'h0, 6'(rnd())}, 1'h1, -1);
        rd(1'h0, 8'h25, 8'h00, 8'h10, 1'h0, -1);
        end_test("single read");
        rd(1'h0, 8'h0e, 8'h03, {2'h0, 6'(rnd())}, 1'h1, -1);
        rd(1'h1, 8'h0e, 8'h03, 8'hf0, 1'h1, -1);
        foreach (badDev[i]) rd(1'h0, 8'h0e, badDev[i], 8'h05, 1'h0, -1);
        rd(1'h1, 8'h0e, 8'h03, 8'h07, 1'h0, 3);
        rd(1'h0, 8'h0e, 8'h03, 8'h07, 1'h1, 4);
        rd(1'h0, 8'h16, 8'h03, {2'h0, 6'(rnd())}, 1'h1, -1);
        @(posedge clk);
        aliveEn <= 1'h0;
        @(posedge clk);
        rd(1'h1, 8'h16, 8'h03, 8'(HIT_LIMIT - 1), 1'h1, -1);
        end_test("block read");
        ho(1'h0, 8'h08, 8'h05, 8'h05, 1'h1, 1'h0);
        ho(1'h0, 8'h09, 8'h05, 8'h05, 1'h1, 1'h1);
        ho(1'h1, 8'h09, 8'h1f, 8'h00, 1'h0, 1'h0);
        ho(1'h1, 8'h09, 8'h04, 8'h04, 1'h0, 1'h0);
        ho(1'h1, 8'h08, 8'h04, 8'h04, 1'h0, 1'h1);
        ho(1'h0, 8'h08, 8'h0a, 8'h0b, 1'h1, 1'h0);
        @(posedge clk);
        dualUartEn <= 1'h0;
        @(posedge clk);
        ho(1'h1, 8'h09, 8'h03, 8'h03, 1'h1, 1'h0);
        end_test("handover");
        check("queues", 16'(expLo.size() + expUp.size()), 16'h0000);
        test_done();
    end

    // All frames together take about two hundred cycles; this margin only cuts a hang
    initial
    begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
endmodule : test_chain_read_and_host_handover
